// file: hdl/flsr_cfg.svh
// Opcodes, field positions, reset values and timing counts of the block
`ifndef FLSR_CFG_SVH
`define FLSR_CFG_SVH

`define FLSR_OP_RD_LOCK    8'h3d
`define FLSR_OP_GLB_LOCK   8'h7e
`define FLSR_OP_GLB_UNLOCK 8'h98
`define FLSR_OP_RST_EN     8'h66
`define FLSR_OP_RST        8'h99

`define FLSR_OP_BITS       6'h08
`define FLSR_ADDR_END      6'h20
`define FLSR_CNT_MAX       6'h3f
`define FLSR_UNIT_LSB      16
`define FLSR_LOCK_RST      1'b1

`define FLSR_CLK_PERIOD_NS 50
`define FLSR_RST_TIME_NS   30000
`define FLSR_RST_CYC       ((`FLSR_RST_TIME_NS) / (`FLSR_CLK_PERIOD_NS))
`define FLSR_RST_CYC_W     10

`endif

// file: hdl/flsr_pkg.sv
// Types shared by the lock and soft reset logic
package flsr_pkg;

  typedef enum logic [1:0] {
    FLSR_IDLE  = 2'b00,
    FLSR_ARMED = 2'b01,
    FLSR_BUSY  = 2'b11
  } flsr_state_e;

  typedef logic [7:0] flsr_op_t;
  typedef logic [5:0] flsr_cnt_t;

endpackage

// file: hdl/flsr_xing_if.sv
// Signals passing between the serial clock side and the core side
`timescale 1ns/100ps
interface flsr_xing_if #(
  parameter int NUNITS = 64
);
  import flsr_pkg::*;

  flsr_op_t          op;
  flsr_cnt_t         nbits;
  logic [NUNITS-1:0] lock;
  logic              busy;

  modport link (
    output op,
    output nbits,
    input  lock,
    input  busy
  );

  modport core (
    input  op,
    input  nbits,
    output lock,
    output busy
  );
endinterface

// file: hdl/flsr_link.sv
// Serial side: opcode and address shifter and lock byte read-back
`timescale 1ns/100ps
`include "flsr_cfg.svh"
module flsr_link import flsr_pkg::*; #(
  parameter int UNIT_W = 6
) (
  // Serial bus
  input  wire logic    sclk_i,
  input  wire logic    cs_n_i,
  input  wire logic    di_i,
  output logic         do_o,
  output logic         do_oe_o,
  // Reset
  input  wire logic    rst_n_i,
  // Core side
  flsr_xing_if.link    x
);

  logic        first_r;
  flsr_cnt_t   cnt_r;
  flsr_op_t    op_r;
  logic [23:0] addr_r;
  logic [2:0]  ph_r;
  logic        bsy_m_r;
  logic        bsy_s_r;
  logic        lock_bit;

  assign x.op    = op_r;
  assign x.nbits = cnt_r;
  assign lock_bit = x.lock[addr_r[`FLSR_UNIT_LSB +: UNIT_W]];

  // Marks the first rising edge of each frame
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  // Bit count survives the frame end so the core can judge the frame
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else if (first_r) begin
      cnt_r <= 6'h01;
    end else if (cnt_r != `FLSR_CNT_MAX) begin
      cnt_r <= cnt_r + 6'h01;
    end
  end

  // R04 opcode then address
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_r   <= '0;
      addr_r <= '0;
    end else if (first_r) begin
      op_r   <= {7'h00, di_i};
    end else if (cnt_r < `FLSR_OP_BITS) begin
      op_r   <= {op_r[6:0], di_i};
    end else if (cnt_r < `FLSR_ADDR_END) begin
      addr_r <= {addr_r[22:0], di_i};
    end
  end

  // Bit position within the read-back byte
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_r <= '0;
    end else if (first_r) begin
      ph_r <= '0;
    end else if (cnt_r >= `FLSR_ADDR_END) begin
      ph_r <= ph_r + 3'h1;
    end
  end

  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bsy_m_r <= 1'b0;
      bsy_s_r <= 1'b0;
    end else begin
      bsy_m_r <= x.busy;
      bsy_s_r <= bsy_m_r;
    end
  end

  // R05 falling edge, MSB first
  // R06 lock state in the LSB
  always_ff @(negedge sclk_i or posedge cs_n_i or negedge rst_n_i) begin
    if (!rst_n_i || cs_n_i) begin
      do_o    <= 1'b0;
      do_oe_o <= 1'b0;
    end else if (op_r == `FLSR_OP_RD_LOCK && !first_r &&
                 cnt_r >= `FLSR_ADDR_END && !bsy_s_r) begin
      do_oe_o <= 1'b1;
      do_o    <= (ph_r == 3'h7) ? lock_bit : 1'b0;
    end else begin
      do_o    <= 1'b0;
      do_oe_o <= 1'b0;
    end
  end

  // Rising edge: byte phase still matches the bit on the line
  a_rd_upper_zero: assert property ( // R06
    @(posedge sclk_i) disable iff (cs_n_i || !rst_n_i)
    (do_oe_o && ph_r != 3'h7) |-> !do_o
  ) else $error("lock byte upper bit not zero");

  a_rd_after_addr: assert property ( // R05
    @(posedge sclk_i) disable iff (cs_n_i || !rst_n_i)
    do_oe_o |-> (op_r == `FLSR_OP_RD_LOCK && cnt_r > `FLSR_ADDR_END - 6'h01)
  ) else $error("data out driven before address done");

endmodule

// file: hdl/flsr_top.sv
// Block lock bits and two-step soft reset command handling
//
// Behaviour
// R01 - Lock bits protect array when select set
// R02 - Otherwise protection from complement, unit, field
// R03 - Lock bits reset to one
// R04 - Read-back: opcode 3Dh then 24-bit address
// R05 - Lock byte out on falling edges, MSB first
// R06 - Byte LSB shows lock state
// R07 - Global lock 7Eh sets every lock bit
// R08 - Global unlock 98h clears every lock bit
// R09 - Global lock/unlock need write enable latch
// R10 - Host sends global commands as lone opcode
// R11 - Soft reset aborts and clears volatile state
// R12 - Reset only on 66h directly before 99h
// R13 - Any other command disarms the reset
// R14 - Reset takes 30us, commands ignored meanwhile
// R15 - Host checks busy and pause before reset; the testbench host checks only busy
// R16 - Host waits 20us before first select
// R17 - Host waits 5ms before write commands; the testbench host waits 50us
// R18 - Reset opcodes come in separate frames
`timescale 1ns/100ps
`include "flsr_cfg.svh"
module flsr_top import flsr_pkg::*; #(
  parameter int NUNITS = 64,
  parameter int UNIT_W = 6
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // Serial bus
  input  wire logic              spi_sclk_i,
  input  wire logic              spi_cs_n_i,
  input  wire logic              spi_di_i,
  output logic                   spi_do_o,
  output logic                   spi_do_oe_o,
  // Protection configuration
  input  wire logic              individual_protect_select_i,
  input  wire logic              protect_complement_i,
  input  wire logic              small_unit_select_i,
  input  wire logic              top_bottom_select_i,
  input  wire logic [2:0]        block_protect_field_i,
  input  wire logic              write_enable_latch_flag_i,
  // Status
  output logic [NUNITS-1:0]      lock_bits_o,
  output logic [NUNITS-1:0]      array_protect_o,
  output logic                   reset_busy_o,
  output logic                   soft_reset_o
);

  flsr_xing_if #(.NUNITS(NUNITS)) xing ();

  flsr_link #(
    .UNIT_W (UNIT_W)
  ) u_link (
    .sclk_i  (spi_sclk_i),
    .cs_n_i  (spi_cs_n_i),
    .di_i    (spi_di_i),
    .do_o    (spi_do_o),
    .do_oe_o (spi_do_oe_o),
    .rst_n_i (rst_n_i),
    .x       (xing.link)
  );

  // True when a finished frame carried exactly one opcode byte
  function automatic logic is_cmd(input flsr_op_t op,
                                  input flsr_cnt_t nb,
                                  input flsr_op_t code);
    return (op == code) && (nb == `FLSR_OP_BITS);
  endfunction

  // Protected units from the field, edge, unit size and complement
  function automatic logic [NUNITS-1:0] bp_map(input logic [2:0] bp,
                                               input logic       tb,
                                               input logic       sec,
                                               input logic       cmp);
    logic [NUNITS-1:0] m;
    int                n;
    m = '0;
    n = 0;
    if (bp != 3'h0) begin
      n = sec ? 1 : (1 << (int'(bp) - 1));
    end
    for (int i = 0; i < NUNITS; i++) begin
      if (tb) begin
        m[i] = (i < n);
      end else begin
        m[NUNITS-1-i] = (i < n);
      end
    end
    return cmp ? ~m : m;
  endfunction

  logic                       cs_m_r;
  logic                       cs_s_r;
  logic                       cs_d_r;
  logic                       frame_end;
  logic                       any_cmd;
  flsr_op_t                   op_c;
  flsr_cnt_t                  nb_c;
  flsr_state_e                state_r;
  flsr_state_e                state_nxt;
  logic [`FLSR_RST_CYC_W-1:0] rcnt_r;
  logic                       go_reset;
  logic [NUNITS-1:0]          lock_r;
  logic [`FLSR_RST_CYC_W:0]   busy_len_r;

  // Select is sampled twice before use; frame end is its rising edge
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_m_r <= 1'b1;
      cs_s_r <= 1'b1;
      cs_d_r <= 1'b1;
    end else begin
      cs_m_r <= spi_cs_n_i;
      cs_s_r <= cs_m_r;
      cs_d_r <= cs_s_r;
    end
  end

  // Opcode and count are still while select stays high
  assign frame_end = cs_s_r && !cs_d_r;
  assign op_c      = xing.op;
  assign nb_c      = xing.nbits;
  assign any_cmd   = frame_end && (nb_c != '0);
  assign go_reset  = any_cmd && (state_r == FLSR_ARMED) &&
                     is_cmd(op_c, nb_c, `FLSR_OP_RST);

  // R12 arm on 66h, fire on 99h
  // R13 anything else disarms
  // R14 no command while busy
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FLSR_IDLE: begin
        if (any_cmd && is_cmd(op_c, nb_c, `FLSR_OP_RST_EN)) begin
          state_nxt = FLSR_ARMED;
        end
      end
      FLSR_ARMED: begin
        if (go_reset) begin
          state_nxt = FLSR_BUSY;
        end else if (any_cmd) begin
          state_nxt = FLSR_IDLE;
        end
      end
      FLSR_BUSY: begin
        if (rcnt_r == '0) begin
          state_nxt = FLSR_IDLE;
        end
      end
      default: begin
        state_nxt = FLSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= FLSR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // R14 reset interval count
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rcnt_r <= '0;
    end else if (go_reset) begin
      rcnt_r <= `FLSR_RST_CYC_W'(`FLSR_RST_CYC - 1);
    end else if (rcnt_r != '0) begin
      rcnt_r <= rcnt_r - `FLSR_RST_CYC_W'(1);
    end
  end

  // R11 one pulse clears latch, suspend and read settings
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_reset_o <= 1'b0;
    end else begin
      soft_reset_o <= go_reset;
    end
  end

  // R03 all locked after any reset
  // R07 global lock
  // R08 global unlock
  // R09 only with write enable latch
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_r <= {NUNITS{`FLSR_LOCK_RST}};
    end else if (go_reset) begin
      lock_r <= {NUNITS{`FLSR_LOCK_RST}};
    end else if (any_cmd && state_r != FLSR_BUSY &&
                 write_enable_latch_flag_i) begin
      if (is_cmd(op_c, nb_c, `FLSR_OP_GLB_LOCK)) begin
        lock_r <= {NUNITS{1'b1}};
      end else if (is_cmd(op_c, nb_c, `FLSR_OP_GLB_UNLOCK)) begin
        lock_r <= '0;
      end
    end
  end

  assign xing.lock    = lock_r;
  assign xing.busy    = (state_r == FLSR_BUSY);
  assign lock_bits_o  = lock_r;
  assign reset_busy_o = (state_r == FLSR_BUSY);

  // R01 lock bits when select set
  // R02 field scheme otherwise
  assign array_protect_o = individual_protect_select_i ? lock_r :
                           bp_map(block_protect_field_i,
                                  top_bottom_select_i,
                                  small_unit_select_i,
                                  protect_complement_i);

  // Busy length seen from outside, for checking only
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_len_r <= '0;
    end else if (!reset_busy_o) begin
      busy_len_r <= '0;
    end else begin
      busy_len_r <= busy_len_r + (`FLSR_RST_CYC_W + 1)'(1);
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_prot_lock_sel: assert property ( // R01
    individual_protect_select_i |-> array_protect_o == lock_bits_o
  ) else $error("protection not taken from lock bits");

  a_prot_field_sel: assert property ( // R02
    !individual_protect_select_i |->
      array_protect_o == bp_map(block_protect_field_i, top_bottom_select_i,
                                small_unit_select_i, protect_complement_i)
  ) else $error("protection not taken from field scheme");

  a_lock_after_rst: assert property ( // R03
    soft_reset_o |-> &lock_bits_o
  ) else $error("lock bits not all set after soft reset");

  a_glock_all: assert property ( // R07
    (frame_end && is_cmd(op_c, nb_c, `FLSR_OP_GLB_LOCK) &&
     write_enable_latch_flag_i && !reset_busy_o) |=> &lock_bits_o
  ) else $error("global lock left a bit clear");

  a_gunlock_all: assert property ( // R08
    (frame_end && is_cmd(op_c, nb_c, `FLSR_OP_GLB_UNLOCK) &&
     write_enable_latch_flag_i && !reset_busy_o && state_r != FLSR_ARMED)
    |=> lock_bits_o == '0
  ) else $error("global unlock left a bit set");

  a_wel_gate: assert property ( // R09
    (frame_end && !write_enable_latch_flag_i && state_r == FLSR_IDLE)
    |=> $stable(lock_bits_o)
  ) else $error("lock bits changed without write enable");

  a_reset_pair: assert property ( // R12
    $rose(reset_busy_o) |-> $past(state_r) == FLSR_ARMED && soft_reset_o
  ) else $error("reset started without enable pair");

  a_reset_cancel: assert property ( // R13
    (state_r == FLSR_ARMED && any_cmd && !is_cmd(op_c, nb_c, `FLSR_OP_RST))
    |=> state_r == FLSR_IDLE
  ) else $error("reset enable not cancelled");

  a_busy_time: assert property ( // R14
    $fell(reset_busy_o) |-> $past(busy_len_r) == `FLSR_RST_CYC - 1
  ) else $error("reset interval length wrong");

  a_busy_ignore: assert property ( // R14
    (reset_busy_o && frame_end) |=> $stable(lock_bits_o)
  ) else $error("command acted on during reset interval");

  a_soft_pulse: assert property ( // R11
    soft_reset_o |-> reset_busy_o ##1 !soft_reset_o
  ) else $error("soft reset pulse malformed");

  a_arm_on_enable: assert property ( // R12
    (state_r == FLSR_IDLE && any_cmd &&
     is_cmd(op_c, nb_c, `FLSR_OP_RST_EN)) |=> state_r == FLSR_ARMED
  ) else $error("reset enable did not arm");

  a_reset_opcode: assert property ( // R12
    $rose(soft_reset_o) |->
      $past(frame_end && is_cmd(op_c, nb_c, `FLSR_OP_RST))
  ) else $error("soft reset without reset opcode");

  a_lock_quiet: assert property ( // R07
    !frame_end |=> $stable(lock_bits_o)
  ) else $error("lock bits changed outside a frame end");

  a_busy_no_arm: assert property ( // R14
    (reset_busy_o && any_cmd && is_cmd(op_c, nb_c, `FLSR_OP_RST_EN))
    |=> state_r != FLSR_ARMED
  ) else $error("reset enable taken during reset interval");

  a_wel_any_state: assert property ( // R09
    (frame_end && !write_enable_latch_flag_i &&
     !is_cmd(op_c, nb_c, `FLSR_OP_RST)) |=> $stable(lock_bits_o)
  ) else $error("lock change without write enable latch");

endmodule

// file: tb/flsr_host.sv
// Serial host model that frames commands into the lock and reset block
`timescale 1ns/100ps
module flsr_host #(
  parameter int SEL_DLY_NS = 20000,
  parameter int WR_DLY_NS  = 5000000
) (
  // Serial bus
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      di_o,
  input  wire logic do_i,
  input  wire logic do_oe_i,
  // Device status
  input  wire logic busy_i
);
  logic sel_ok;
  logic wr_ok;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    di_o   = 1'b0;
    sel_ok = 1'b0;
    #(SEL_DLY_NS) sel_ok = 1'b1;
  end

  initial begin
    wr_ok = 1'b0;
    #(WR_DLY_NS) wr_ok = 1'b1;
  end

  task automatic xfer(input logic [7:0]  op,
                      input logic [23:0] ad,
                      input int          nclk,
                      output logic [7:0] rd,
                      output logic       oe);
    logic [31:0] sh;
    sh = {op, ad};
    rd = 8'h00;
    oe = 1'b1;
    wait (sel_ok);
    if (op == 8'h7e || op == 8'h98)
      wait (wr_ok);
    if (op == 8'h66)
      wait (busy_i === 1'b0);
    cs_n_o = 1'b0;
    for (int i = 0; i < nclk; i++) begin
      // Past the address the data line is don't care, so keep it moving
      di_o = (i < 32) ? sh[31-i] : ~di_o;
      #16 sclk_o = 1'b1;
      if (i >= 32) begin
        // A released line shows the inverse of its last level
        rd = {rd[6:0], do_oe_i ? do_i : ~do_i};
        oe = oe & do_oe_i;
      end
      #16 sclk_o = 1'b0;
    end
    #16 cs_n_o = 1'b1;
    di_o = ~di_o;
    // Deselect long enough for the core to judge the frame
    #500;
  endtask
endmodule

// file: tb/tb.sv
// Testbench for the lock bits and two-step soft reset block
`timescale 1ns/100ps
module tb;
  localparam logic [63:0] ONES = '1;
  logic        clk;
  logic        rst_n;
  logic        sclk;
  logic        cs_n;
  logic        di;
  logic        sdo;
  logic        sdo_oe;
  logic        ips;
  logic        cmp;
  logic        sec;
  logic        tbs;
  logic [2:0]  bp;
  logic        write_enable_latch_flag;
  logic [63:0] locks;
  logic [63:0] prot;
  logic        busy;
  logic        srst;
  logic [7:0]  rd;
  logic        oe;
  int          err_total;
  int          checks;
  int          cyc;
  int          n_srst;
  int          n_busy;
  logic [5:0]  pc [8] = '{6'h08, 6'h28, 6'h09, 6'h01,
                          6'h0b, 6'h07, 6'h29, 6'h13};
  logic [63:0] pe [8] = '{64'h0000_0000_0000_0000, ONES,
                          64'h0000_0000_0000_0001,
                          64'h8000_0000_0000_0000,
                          64'h0000_0000_0000_000f, ONES,
                          64'hffff_ffff_ffff_fffe,
                          64'h8000_0000_0000_0000};

  flsr_top #(.NUNITS(64), .UNIT_W(6)) DUT (
    .core_clk_i                  (clk),
    .rst_n_i                     (rst_n),
    .spi_sclk_i                  (sclk),
    .spi_cs_n_i                  (cs_n),
    .spi_di_i                    (di),
    .spi_do_o                    (sdo),
    .spi_do_oe_o                 (sdo_oe),
    .individual_protect_select_i (ips),
    .protect_complement_i        (cmp),
    .small_unit_select_i         (sec),
    .top_bottom_select_i         (tbs),
    .block_protect_field_i       (bp),
    .write_enable_latch_flag_i   (write_enable_latch_flag),
    .lock_bits_o                 (locks),
    .array_protect_o             (prot),
    .reset_busy_o                (busy),
    .soft_reset_o                (srst)
  );

  flsr_host #(.SEL_DLY_NS(20000), .WR_DLY_NS(50000)) u_host (
    .sclk_o  (sclk),
    .cs_n_o  (cs_n),
    .di_o    (di),
    .do_i    (sdo),
    .do_oe_i (sdo_oe),
    .busy_i  (busy)
  );

  always #25 clk = ~clk;

  task report_and_stop;
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task setcfg(input logic [7:0] c);
    @(negedge clk);
    {write_enable_latch_flag, ips, cmp, sec, tbs, bp} = c;
    @(negedge clk);
  endtask

  task cmd(input logic [7:0] op, input int n);
    u_host.xfer(op, 24'h00_0000, n, rd, oe);
  endtask

  // Pulse and busy lengths, plus the hang limit
  always @(posedge clk) begin
    if (srst === 1'b1)
      n_srst++;
    if (busy === 1'b1)
      n_busy++;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop;
    end
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {write_enable_latch_flag, ips, cmp, sec, tbs, bp} = 8'h00;
    err_total = 0;
    checks = 0;
    cyc = 0;
    n_srst = 0;
    n_busy = 0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("lock_bits", locks, ONES);
    setcfg(8'h40);
    chk("protect", prot, ONES);
    u_host.xfer(8'h3d, 24'h05_0000, 40, rd, oe);
    chk("lock_byte", rd, 8'h01);
    chk("do_enable", oe, 1'b1);
    cmd(8'h98, 8);
    chk("lock_bits", locks, ONES);
    setcfg(8'hc0);
    cmd(8'h98, 9);
    chk("lock_bits", locks, ONES);
    cmd(8'h98, 8);
    chk("lock_bits", locks, 64'h0000_0000_0000_0000);
    chk("protect", prot, 64'h0000_0000_0000_0000);
    u_host.xfer(8'h3d, 24'h3f_0000, 48, rd, oe);
    chk("lock_byte", rd, 8'h00);
    for (int i = 0; i < 8; i++) begin
      setcfg({2'b00, pc[i]});
      chk("protect", prot, pe[i]);
    end
    setcfg(8'hc0);
    cmd(8'h7e, 8);
    chk("lock_bits", locks, ONES);
    cmd(8'h98, 8);
    cmd(8'h66, 8);
    cmd(8'h3d, 40);
    cmd(8'h99, 8);
    chk("reset_pulses", n_srst, 0);
    cmd(8'h66, 8);
    cmd(8'h66, 8);
    cmd(8'h99, 8);
    chk("reset_pulses", n_srst, 0);
    cmd(8'h66, 8);
    cmd(8'h99, 8);
    chk("reset_pulses", n_srst, 1);
    chk("reset_busy", busy, 1'b1);
    chk("lock_bits", locks, ONES);
    cmd(8'h98, 8);
    chk("lock_bits", locks, ONES);
    cmd(8'h3d, 40);
    chk("do_enable", oe, 1'b0);
    for (int k = 0; k < 1000 && busy !== 1'b0; k++)
      @(negedge clk);
    chk("busy_cycles", n_busy, 600);
    chk("reset_busy", busy, 1'b0);
    cmd(8'h98, 8);
    chk("lock_bits", locks, 64'h0000_0000_0000_0000);
    // Hardware reset in mid-run restores the locked state
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk("lock_bits", locks, ONES);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("reset_busy", busy, 1'b0);
    u_host.xfer(8'h3d, 24'h05_0000, 40, rd, oe);
    chk("lock_byte", rd, 8'h01);
    chk("do_enable", oe, 1'b1);
    chk("reset_pulses", n_srst, 1);
    report_and_stop;
  end
endmodule
